// >>> design/cfg_order_pkg.sv
package cfg_order_pkg;
	// ------------------------------------------------------------
	// Widths and modes
	// ------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int BUS_W = 32;
	localparam logic [1:0] WIDTH_X8 = 2'h0;
	localparam logic [1:0] WIDTH_X16 = 2'h1;
	localparam logic [1:0] WIDTH_X32 = 2'h2;
	localparam logic [31:0] SYNC_WORD = 32'haa995566;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	localparam logic [2:0] ZERO_CNT = 3'h0;
	localparam logic [2:0] BYTES_X8 = 3'h1;
	localparam logic [2:0] BYTES_X16 = 3'h2;
	localparam logic [2:0] BYTES_X32 = 3'h4;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] data;
		logic valid;
	} cfg_beat_t;

	typedef enum logic [2:0] {
		ST_HUNT = 3'h1,
		ST_LOAD = 3'h2,
		ST_DONE = 3'h4
	} order_state_t;
endpackage

// >>> design/lane_reverse.sv
`timescale 1ns/10ps
module lane_reverse
	import cfg_order_pkg::*;
#(
	parameter int LANES = 4
) (
	input wire logic [LANES*BYTE_W-1:0] raw_i,
	output logic [LANES*BYTE_W-1:0] ordered_o
);
	// ------------------------------------------------------------
	// Per-lane bit reversal, byte order kept
	// ------------------------------------------------------------
	genvar l, b;
	generate
		for (l = 0; l < LANES; l++) begin : g_lane
			for (b = 0; b < BYTE_W; b++) begin : g_bit
				// Pin 0 of each lane is the byte's MSB
				assign ordered_o[l*BYTE_W + BYTE_W-1-b] = raw_i[l*BYTE_W + b];
			end
		end
	endgenerate
endmodule

// >>> design/config_data_bit_order.sv
`timescale 1ns/10ps
// Function
// - x8: one byte per clock, MSB on pin 0
// - Same order for flash and internal port
// - x16/x32: reverse each lane, keep byte order
// - Chain head uses first stream, ignores rest
module config_data_bit_order
	import cfg_order_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic config_clock_i,
	input wire logic [1:0] bus_width_i,
	input wire logic internal_port_i,
	input wire logic parallel_flash_mode_i,
	input wire logic [BUS_W-1:0] data_pins_i,
	input wire logic data_valid_i,
	input wire logic stream_end_i,
	input wire logic [BUS_W-1:0] icap_data_i,
	input wire logic icap_valid_i,
	output logic [BUS_W-1:0] cfg_word_o,
	output logic cfg_word_valid_o,
	output logic synced_o,
	output logic configured_o
);
	// ------------------------------------------------------------
	// Link side: sample pins on the configuration clock
	// ------------------------------------------------------------
	logic [BUS_W-1:0] ordered;
	logic [BUS_W-1:0] link_word, next_link_word;
	logic [2:0] link_cnt, next_link_cnt;
	logic link_tog, next_link_tog;
	logic [BUS_W-1:0] link_hold, next_link_hold;
	logic [2:0] lane_bytes;
	logic [BUS_W-1:0] src;
	logic src_valid;

	// Internal port shares the same pin ordering
	assign src = internal_port_i ? icap_data_i : data_pins_i;
	assign src_valid = internal_port_i ? icap_valid_i : data_valid_i;

	lane_reverse #(
		.LANES(BUS_W / BYTE_W)
	) u_rev (
		.raw_i(src),
		.ordered_o(ordered)
	);

	always_comb begin
		case (bus_width_i)
			WIDTH_X16: lane_bytes = BYTES_X16;
			WIDTH_X32: lane_bytes = BYTES_X32;
			default: lane_bytes = BYTES_X8;
		endcase
		// Flash mode is x8 or x16 here; x32 flash runs as x16
		if (parallel_flash_mode_i && bus_width_i == WIDTH_X32) begin
			lane_bytes = BYTES_X16;
		end
	end

	always_comb begin
		next_link_word = link_word;
		next_link_cnt = link_cnt;
		next_link_tog = link_tog;
		next_link_hold = link_hold;
		if (src_valid) begin
			// Earliest byte ends in the top lane
			case (lane_bytes)
				BYTES_X32: next_link_word = ordered;
				BYTES_X16: next_link_word = {link_word[15:0], ordered[15:0]};
				default: next_link_word = {link_word[23:0], ordered[7:0]};
			endcase
			if (link_cnt + lane_bytes >= BYTES_X32) begin
				next_link_cnt = ZERO_CNT;
				next_link_hold = next_link_word;
				next_link_tog = ~link_tog;
			end else begin
				next_link_cnt = link_cnt + lane_bytes;
			end
		end
	end

	// Link clock may stop between frames; reset is sampled only on its rising edges
	always_ff @(posedge config_clock_i) begin
		if (rst_i) begin
			link_word <= ZERO_WORD;
			link_cnt <= ZERO_CNT;
			link_tog <= 1'b0;
			link_hold <= ZERO_WORD;
		end else begin
			link_word <= next_link_word;
			link_cnt <= next_link_cnt;
			link_tog <= next_link_tog;
			link_hold <= next_link_hold;
		end
	end

	// ------------------------------------------------------------
	// Crossing: toggle through three flops, word held stable
	// ------------------------------------------------------------
	logic tog_s1, tog_s2, tog_s3, tog_seen;
	logic end_s1, end_s2, end_s3;
	logic word_evt, end_evt;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			tog_seen <= 1'b0;
			end_s1 <= 1'b0;
			end_s2 <= 1'b0;
			end_s3 <= 1'b0;
		end else begin
			tog_s1 <= link_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			tog_seen <= (tog_s2 == tog_s3) ? tog_s3 : tog_seen;
			end_s1 <= stream_end_i;
			end_s2 <= end_s1;
			end_s3 <= end_s2;
		end
	end

	// Hold word is written on the same link edge as the toggle; the event fires once the toggle reaches the third flop
	assign word_evt = (tog_s2 == tog_s3) && (tog_s3 != tog_seen);
	assign end_evt = end_s2 && end_s3;

	// ------------------------------------------------------------
	// Sync search and stream control
	// ------------------------------------------------------------
	order_state_t state, next_state;
	logic [BUS_W-1:0] next_cfg_word;
	logic next_cfg_valid;

	always_comb begin
		next_state = state;
		next_cfg_word = cfg_word_o;
		next_cfg_valid = 1'b0;
		case (state)
			ST_HUNT: begin
				// Search on reordered words
				if (word_evt && link_hold == SYNC_WORD) begin
					next_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (word_evt) begin
					next_cfg_word = link_hold;
					next_cfg_valid = 1'b1;
				end
				if (end_evt) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				// Later streams are dropped
				next_state = ST_DONE;
			end
			default: next_state = ST_HUNT;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= ST_HUNT;
			cfg_word_o <= ZERO_WORD;
			cfg_word_valid_o <= 1'b0;
		end else begin
			state <= next_state;
			cfg_word_o <= next_cfg_word;
			cfg_word_valid_o <= next_cfg_valid;
		end
	end

	assign synced_o = (state != ST_HUNT);
	assign configured_o = (state == ST_DONE);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_done;
		state == ST_DONE;
	endsequence

	AST_DONE_SILENT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		s_done |=> !cfg_word_valid_o && configured_o)
		else $error("Data passed after first stream");

	AST_SYNC_FIRST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cfg_word_valid_o |-> $past(state) == ST_LOAD)
		else $error("Word passed before sync");

	AST_SYNC_HIT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ST_HUNT && word_evt && link_hold == SYNC_WORD) |=> synced_o)
		else $error("Sync word missed");

	AST_LANE_MSB: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ordered[BYTE_W-1] == src[0])
		else $error("Pin 0 not mapped to MSB");

	AST_LANE_ORDER: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ordered[BUS_W-1] == src[BUS_W-BYTE_W] && ordered[BUS_W-BYTE_W] == src[BUS_W-1])
		else $error("Top lane not reversed in place");

	AST_ICAP_PATH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		internal_port_i |-> ordered[BYTE_W-1] == icap_data_i[0])
		else $error("Internal port not reordered");

	AST_END_LATCH: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ST_LOAD && end_evt) |=> configured_o ##1 configured_o)
		else $error("Stream end not taken");

	AST_WORD_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ST_LOAD && word_evt) |=> cfg_word_valid_o && cfg_word_o == $past(link_hold))
		else $error("Word not forwarded");
endmodule

// >>> bench/cfg_host.sv
`timescale 1ns/10ps
module cfg_host
	import cfg_order_pkg::*;
(
	input wire logic link_clk_i,
	output logic [BUS_W-1:0] pins_o,
	output logic valid_o
);
	initial begin
		pins_o = ZERO_WORD;
		valid_o = 1'b0;
	end
	function automatic logic [31:0] swap(input logic [31:0] w);
		for (int i = 0; i < 32; i++) begin
			swap[i] = w[(i & ~7) + 7 - (i & 7)];
		end
	endfunction
	// Payload only; unused lanes toggle so stale bits never match
	task automatic send(input logic [31:0] w, input int n);
		logic [31:0] p;
		logic [31:0] q;
		p = swap(w);
		for (int i = 0; i < n; i++) begin
			@(posedge link_clk_i);
			#1;
			// Built aside so the pins change once per beat
			q = ~pins_o;
			if (n == 1) q = p;
			else if (n == 2) q[15:0] = p[31-16*i -: 16];
			else q[7:0] = p[31-8*i -: 8];
			pins_o = q;
			valid_o = 1'b1;
		end
		@(posedge link_clk_i);
		#1;
		valid_o = 1'b0;
		pins_o = ~pins_o;
		repeat (17) @(posedge link_clk_i); // Spacing for the toggle crossing
	endtask
endmodule

// >>> bench/test_config_data_bit_order.sv
`timescale 1ns/10ps
module test_config_data_bit_order
	import cfg_order_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic free_clk = 1'b0;
	logic run = 1'b1;
	logic link_en = 1'b1;
	logic [1:0] width = WIDTH_X8;
	logic internal = 1'b0;
	logic flash = 1'b0;
	logic stream_end = 1'b0;
	logic [BUS_W-1:0] pins, word, got;
	logic pins_valid, word_valid, synced, configured;
	int fail_count = 0;
	int comparisons = 0;
	int ngot = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	always #6 free_clk = ~free_clk;
	always @(negedge free_clk) link_en <= run;
	wire logic config_clock = free_clk & link_en;
	cfg_host host (.link_clk_i(config_clock), .pins_o(pins), .valid_o(pins_valid));
	config_data_bit_order dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.config_clock_i(config_clock), .bus_width_i(width), .internal_port_i(internal),
		.parallel_flash_mode_i(flash), .data_pins_i(pins),
		.data_valid_i(pins_valid & ~internal), .stream_end_i(stream_end),
		.icap_data_i(pins), .icap_valid_i(pins_valid & internal), .cfg_word_o(word),
		.cfg_word_valid_o(word_valid), .synced_o(synced), .configured_o(configured));
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			ngot <= 0;
		end else if (word_valid === 1'b1) begin
			got <= word;
			ngot <= ngot + 1;
		end
	end
	// ----------------
	// Helpers
	// ----------------
	task automatic close_out();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
		comparisons++;
		if (exp !== act) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, act);
		end
	endtask
	task automatic wait_words(input int n);
		for (int i = 0; i < 40 && ngot < n; i++) @(posedge clk_sys_i);
		chk("word count", n, ngot);
		if (ngot < n) close_out();
	endtask
	// Modes stay static for the whole stream, so each stream starts from reset
	task automatic stream(input logic [1:0] wd, input logic il, input logic fl,
		input logic [31:0] w, input int n);
		@(posedge clk_sys_i);
		#1;
		rst_i = 1'b1;
		width = wd;
		internal = il;
		flash = fl;
		run = 1'b1;
		repeat (16) @(posedge clk_sys_i);
		#1;
		chk("reset state", 32'h0, {word_valid, synced, configured});
		rst_i = 1'b0;
		host.send(32'h1e2d3c4b, n);
		host.send(SYNC_WORD, n);
		chk("synced", 32'h1, synced);
		chk("dropped before sync", 32'h0, ngot);
		host.send(w, n);
		wait_words(1);
		chk("word", w, got);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic sc_x8();
		stream(WIDTH_X8, 1'b0, 1'b0, 32'h8c35a1e0, 4);
		run = 1'b0;
	endtask
	task automatic sc_x16();
		stream(WIDTH_X16, 1'b0, 1'b0, 32'h01f48b36, 2);
		run = 1'b0;
	endtask
	task automatic sc_x32();
		stream(WIDTH_X32, 1'b0, 1'b0, 32'he0375a1c, 1);
		run = 1'b0;
	endtask
	// Flash asking for x32 falls back to x16 lanes
	task automatic sc_flash();
		stream(WIDTH_X8, 1'b0, 1'b1, 32'h4d21f086, 4);
		stream(WIDTH_X32, 1'b0, 1'b1, 32'h5b0e27c4, 2);
		run = 1'b0;
	endtask
	task automatic sc_icap();
		stream(WIDTH_X32, 1'b1, 1'b0, 32'h70b3c91e, 1);
		run = 1'b0;
	endtask
	task automatic sc_chain();
		stream(WIDTH_X8, 1'b0, 1'b0, 32'h35e08ca1, 4);
		@(posedge clk_sys_i);
		#1;
		stream_end = 1'b1;
		for (int i = 0; i < 20 && configured !== 1'b1; i++) @(posedge clk_sys_i);
		chk("configured", 32'h1, configured);
		host.send(SYNC_WORD, 4);
		host.send(32'h96a50f3c, 4);
		repeat (10) @(posedge clk_sys_i);
		chk("later stream ignored", 32'h1, ngot);
		chk("kept word", 32'h35e08ca1, got);
		#1;
		stream_end = 1'b0;
		run = 1'b0;
	endtask
	initial begin
		sc_x8();
		sc_x16();
		sc_x32();
		sc_flash();
		sc_icap();
		sc_chain();
		close_out();
	end
	initial begin
		#2000000;
		fail_count++;
		$display("[FAIL] run time expected end seen timeout");
		close_out();
	end
endmodule
